/* verilog/sfx_pkg.sv */
// Constants and types for the status-flag instruction execution block
package sfx_pkg;

   // ----------------------------------------------------------------
   // Status register layout
   // ----------------------------------------------------------------
   localparam int unsigned SFX_FLAG_C = 0;  // Carry
   localparam int unsigned SFX_FLAG_Z = 1;  // Zero
   localparam int unsigned SFX_FLAG_N = 2;  // Negative
   localparam int unsigned SFX_FLAG_V = 3;  // Two's complement overflow
   localparam int unsigned SFX_FLAG_S = 4;  // Sign
   localparam int unsigned SFX_FLAG_H = 5;  // Half-carry
   localparam int unsigned SFX_FLAG_T = 6;  // Transfer
   localparam int unsigned SFX_FLAG_I = 7;  // Global interrupt enable
   localparam logic [7:0]  SFX_STATUS_RST = 8'h00;

   // ----------------------------------------------------------------
   // Execution timing
   // ----------------------------------------------------------------
   localparam int unsigned SFX_EXEC_CYCLES = 1;  // Every op here takes one cycle

   // ----------------------------------------------------------------
   // Operation codes
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      SFX_OP_NO_OPERATION,
      SFX_OP_BIT_LOAD_FROM_TRANSFER,
      SFX_OP_SET_CARRY,
      SFX_OP_CLEAR_CARRY,
      SFX_OP_SET_NEGATIVE,
      SFX_OP_CLEAR_NEGATIVE,
      SFX_OP_SET_ZERO,
      SFX_OP_CLEAR_ZERO,
      SFX_OP_SET_INT_ENABLE,
      SFX_OP_CLEAR_INT_ENABLE,
      SFX_OP_SET_SIGN_FLAG,
      SFX_OP_CLEAR_SIGN_FLAG,
      SFX_OP_SET_OVERFLOW,
      SFX_OP_CLEAR_OVERFLOW,
      SFX_OP_SET_TRANSFER,
      SFX_OP_CLEAR_TRANSFER,
      SFX_OP_SET_HALF_CARRY,
      SFX_OP_CLEAR_HALF_CARRY,
      SFX_OP_SLEEP,
      SFX_OP_WATCHDOG_RESTART
   } sfx_op_t;

   // One-hot mask for a bit position
   function automatic logic [7:0] sfx_onehot(input logic [2:0] idx);
      sfx_onehot = 8'h01 << idx;
   endfunction

endpackage : sfx_pkg

/* verilog/sfx_decode.sv */
// Opcode decoder for the status-flag instruction execution block
module sfx_decode
   import sfx_pkg::*;
(
   input  wire logic [4:0] i_op,
   output logic       [7:0] o_set_mask,
   output logic       [7:0] o_clr_mask,
   output logic             o_bit_load,
   output logic             o_sleep,
   output logic             o_wdt,
   output logic             o_legal
);

   // ----------------------------------------------------------------
   // Opcode to flag masks and side-effect strobes
   // ----------------------------------------------------------------
   always_comb begin
      o_set_mask = 8'h00;
      o_clr_mask = 8'h00;
      o_bit_load = 1'b0;
      o_sleep    = 1'b0;
      o_wdt      = 1'b0;
      o_legal    = 1'b1;
      unique case (i_op)
         SFX_OP_NO_OPERATION:           o_legal = 1'b1;
         SFX_OP_BIT_LOAD_FROM_TRANSFER: o_bit_load = 1'b1;
         SFX_OP_SET_CARRY:              o_set_mask = sfx_onehot(3'(SFX_FLAG_C));
         SFX_OP_CLEAR_CARRY:            o_clr_mask = sfx_onehot(3'(SFX_FLAG_C));
         SFX_OP_SET_NEGATIVE:           o_set_mask = sfx_onehot(3'(SFX_FLAG_N));
         SFX_OP_CLEAR_NEGATIVE:         o_clr_mask = sfx_onehot(3'(SFX_FLAG_N));
         SFX_OP_SET_ZERO:               o_set_mask = sfx_onehot(3'(SFX_FLAG_Z));
         SFX_OP_CLEAR_ZERO:             o_clr_mask = sfx_onehot(3'(SFX_FLAG_Z));
         SFX_OP_SET_INT_ENABLE:         o_set_mask = sfx_onehot(3'(SFX_FLAG_I));
         SFX_OP_CLEAR_INT_ENABLE:       o_clr_mask = sfx_onehot(3'(SFX_FLAG_I));
         SFX_OP_SET_SIGN_FLAG:          o_set_mask = sfx_onehot(3'(SFX_FLAG_S));
         SFX_OP_CLEAR_SIGN_FLAG:        o_clr_mask = sfx_onehot(3'(SFX_FLAG_S));
         SFX_OP_SET_OVERFLOW:           o_set_mask = sfx_onehot(3'(SFX_FLAG_V));
         SFX_OP_CLEAR_OVERFLOW:         o_clr_mask = sfx_onehot(3'(SFX_FLAG_V));
         SFX_OP_SET_TRANSFER:           o_set_mask = sfx_onehot(3'(SFX_FLAG_T));
         SFX_OP_CLEAR_TRANSFER:         o_clr_mask = sfx_onehot(3'(SFX_FLAG_T));
         SFX_OP_SET_HALF_CARRY:         o_set_mask = sfx_onehot(3'(SFX_FLAG_H));
         SFX_OP_CLEAR_HALF_CARRY:       o_clr_mask = sfx_onehot(3'(SFX_FLAG_H));
         SFX_OP_SLEEP:                  o_sleep = 1'b1;
         SFX_OP_WATCHDOG_RESTART:       o_wdt = 1'b1;
         default:                       o_legal = 1'b0;              // Unused codes
      endcase
   end

endmodule : sfx_decode

/* verilog/sfx_exec.sv */
// Single-cycle status-flag, bit-load, no-op, sleep and watchdog-restart execution
module sfx_exec
   import sfx_pkg::*;
#(
   parameter int unsigned REG_ADDR_W = 5
)(
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_n,
   input  wire logic                  i_valid,
   input  wire logic [4:0]            i_op,
   input  wire logic [REG_ADDR_W-1:0] i_rd_addr,
   input  wire logic [2:0]            i_bit_sel,
   input  wire logic [7:0]            i_rd_data,
   output logic      [7:0]            o_status,
   output logic                       o_rd_we,
   output logic      [REG_ADDR_W-1:0] o_rd_waddr,
   output logic      [7:0]            o_rd_wdata,
   output logic                       o_sleep_req,
   output logic                       o_wdt_restart,
   output logic                       o_pc_advance,
   output logic                       o_illegal
);

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic [7:0] set_mask;
   logic [7:0] clr_mask;
   logic       dec_bit_load;
   logic       dec_sleep;
   logic       dec_wdt;
   logic       dec_legal;
   logic       exec;

   sfx_decode u_decode (
      .i_op       (i_op),
      .o_set_mask (set_mask),
      .o_clr_mask (clr_mask),
      .o_bit_load (dec_bit_load),
      .o_sleep    (dec_sleep),
      .o_wdt      (dec_wdt),
      .o_legal    (dec_legal)
   );

   // Legal instruction taken this cycle
   assign exec = i_valid && dec_legal;

   // ----------------------------------------------------------------
   // Status register
   // ----------------------------------------------------------------
   logic [7:0] status_q;
   logic [7:0] status_d;

   // Only the named flag moves; other ops leave the register alone
   always_comb begin
      status_d = status_q;
      if (exec) begin
         status_d = (status_q | set_mask) & ~clr_mask;
      end
   end

   // Status update
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         status_q <= SFX_STATUS_RST;
      end else begin
         status_q <= status_d;
      end
   end

   assign o_status = status_q;

   // ----------------------------------------------------------------
   // Register-file write for bit-load
   // ----------------------------------------------------------------
   logic                  rd_we_q;
   logic [REG_ADDR_W-1:0] rd_waddr_q;
   logic [7:0]            rd_wdata_q;
   logic [7:0]            bit_mask;

   assign bit_mask = sfx_onehot(i_bit_sel);

   // Replace the chosen bit with the transfer flag
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_we_q    <= 1'b0;
         rd_waddr_q <= '0;
         rd_wdata_q <= 8'h00;
      end else begin
         rd_we_q <= exec && dec_bit_load;
         if (exec && dec_bit_load) begin
            rd_waddr_q <= i_rd_addr;
            rd_wdata_q <= (i_rd_data & ~bit_mask)
                        | (status_q[SFX_FLAG_T] ? bit_mask : 8'h00);
         end
      end
   end

   assign o_rd_we    = rd_we_q;
   assign o_rd_waddr = rd_waddr_q;
   assign o_rd_wdata = rd_wdata_q;

   // ----------------------------------------------------------------
   // Side-effect strobes and completion
   // ----------------------------------------------------------------
   logic sleep_q;
   logic wdt_q;
   logic pc_adv_q;
   logic illegal_q;

   // One-cycle pulses after the issuing edge
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sleep_q   <= 1'b0;
         wdt_q     <= 1'b0;
         pc_adv_q  <= 1'b0;
         illegal_q <= 1'b0;
      end else begin
         sleep_q   <= exec && dec_sleep;
         wdt_q     <= exec && dec_wdt;
         pc_adv_q  <= exec;
         illegal_q <= i_valid && !dec_legal;
      end
   end

   assign o_sleep_req   = sleep_q;
   assign o_wdt_restart = wdt_q;
   assign o_pc_advance  = pc_adv_q;
   assign o_illegal     = illegal_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   localparam logic [7:0] MASK_S = 8'h01 << SFX_FLAG_S;
   localparam logic [7:0] MASK_V = 8'h01 << SFX_FLAG_V;
   localparam logic [7:0] MASK_H = 8'h01 << SFX_FLAG_H;
   localparam logic [7:0] MASK_C = 8'h01 << SFX_FLAG_C;
   localparam logic [7:0] MASK_I = 8'h01 << SFX_FLAG_I;
   localparam logic [7:0] MASK_Z = 8'h01 << SFX_FLAG_Z;
   localparam logic [7:0] MASK_N = 8'h01 << SFX_FLAG_N;
   localparam logic [7:0] MASK_T = 8'h01 << SFX_FLAG_T;

   function automatic logic took(input sfx_op_t op);
      took = i_valid && (i_op == op);
   endfunction

   bit_load_a: assert property (took(SFX_OP_BIT_LOAD_FROM_TRANSFER) |=> o_rd_we
      && o_rd_wdata[$past(i_bit_sel)] == $past(o_status[SFX_FLAG_T])
      && (o_rd_wdata & ~sfx_onehot($past(i_bit_sel))) == ($past(i_rd_data) & ~sfx_onehot($past(i_bit_sel)))
      && o_status == $past(o_status))
      else $error("bit load result wrong");

   sign_set_a: assert property (took(SFX_OP_SET_SIGN_FLAG) |=> o_status[SFX_FLAG_S]
      && (o_status & ~MASK_S) == ($past(o_status) & ~MASK_S))
      else $error("sign set wrong");

   sign_clear_a: assert property (took(SFX_OP_CLEAR_SIGN_FLAG) |=> !o_status[SFX_FLAG_S]
      && (o_status & ~MASK_S) == ($past(o_status) & ~MASK_S))
      else $error("sign clear wrong");

   ovf_set_a: assert property (took(SFX_OP_SET_OVERFLOW) |=> o_status[SFX_FLAG_V]
      && (o_status & ~MASK_V) == ($past(o_status) & ~MASK_V))
      else $error("overflow set wrong");

   ovf_clear_a: assert property (took(SFX_OP_CLEAR_OVERFLOW) |=> !o_status[SFX_FLAG_V]
      && (o_status & ~MASK_V) == ($past(o_status) & ~MASK_V))
      else $error("overflow clear wrong");

   half_set_a: assert property (took(SFX_OP_SET_HALF_CARRY) |=> o_status[SFX_FLAG_H]
      && (o_status & ~MASK_H) == ($past(o_status) & ~MASK_H))
      else $error("half carry set wrong");

   half_clear_a: assert property (took(SFX_OP_CLEAR_HALF_CARRY) |=> !o_status[SFX_FLAG_H]
      && (o_status & ~MASK_H) == ($past(o_status) & ~MASK_H))
      else $error("half carry clear wrong");

   sleep_issue_a: assert property (took(SFX_OP_SLEEP) |=> o_sleep_req && $stable(o_status)
      ##1 !o_sleep_req || $past(took(SFX_OP_SLEEP)))
      else $error("sleep issue wrong");

   wdt_issue_a: assert property (took(SFX_OP_WATCHDOG_RESTART) |=> o_wdt_restart
      && $stable(o_status) && !o_sleep_req)
      else $error("watchdog restart issue wrong");

   carry_set_a: assert property (took(SFX_OP_SET_CARRY) |=> o_status[SFX_FLAG_C]
      && (o_status & ~MASK_C) == ($past(o_status) & ~MASK_C))
      else $error("carry set wrong");

   int_clear_a: assert property (took(SFX_OP_CLEAR_INT_ENABLE) |=> !o_status[SFX_FLAG_I]
      && (o_status & ~MASK_I) == ($past(o_status) & ~MASK_I))
      else $error("interrupt disable wrong");

   carry_clear_a: assert property (took(SFX_OP_CLEAR_CARRY) |=> !o_status[SFX_FLAG_C]
      && (o_status & ~MASK_C) == ($past(o_status) & ~MASK_C))
      else $error("carry clear wrong");

   zero_set_a: assert property (took(SFX_OP_SET_ZERO) |=> o_status[SFX_FLAG_Z]
      && (o_status & ~MASK_Z) == ($past(o_status) & ~MASK_Z))
      else $error("zero set wrong");

   zero_clear_a: assert property (took(SFX_OP_CLEAR_ZERO) |=> !o_status[SFX_FLAG_Z]
      && (o_status & ~MASK_Z) == ($past(o_status) & ~MASK_Z))
      else $error("zero clear wrong");

   neg_set_a: assert property (took(SFX_OP_SET_NEGATIVE) |=> o_status[SFX_FLAG_N]
      && (o_status & ~MASK_N) == ($past(o_status) & ~MASK_N))
      else $error("negative set wrong");

   neg_clear_a: assert property (took(SFX_OP_CLEAR_NEGATIVE) |=> !o_status[SFX_FLAG_N]
      && (o_status & ~MASK_N) == ($past(o_status) & ~MASK_N))
      else $error("negative clear wrong");

   tflag_set_a: assert property (took(SFX_OP_SET_TRANSFER) |=> o_status[SFX_FLAG_T]
      && (o_status & ~MASK_T) == ($past(o_status) & ~MASK_T))
      else $error("transfer set wrong");

   tflag_clear_a: assert property (took(SFX_OP_CLEAR_TRANSFER) |=> !o_status[SFX_FLAG_T]
      && (o_status & ~MASK_T) == ($past(o_status) & ~MASK_T))
      else $error("transfer clear wrong");

   int_set_a: assert property (took(SFX_OP_SET_INT_ENABLE) |=> o_status[SFX_FLAG_I]
      && (o_status & ~MASK_I) == ($past(o_status) & ~MASK_I))
      else $error("interrupt enable wrong");

   nop_quiet_a: assert property (took(SFX_OP_NO_OPERATION) |=> o_pc_advance && !o_rd_we
      && !o_sleep_req && !o_wdt_restart && $stable(o_status))
      else $error("no-op changed state");

   bit_load_c: cover property (took(SFX_OP_BIT_LOAD_FROM_TRANSFER) && status_q[SFX_FLAG_T]);
   set_clear_c: cover property (took(SFX_OP_SET_SIGN_FLAG) ##1 took(SFX_OP_CLEAR_SIGN_FLAG));
   sleep_c: cover property (took(SFX_OP_SLEEP));
   wdt_c: cover property (took(SFX_OP_WATCHDOG_RESTART));

endmodule : sfx_exec

/* dv/testbench.sv */
// Self-checking bench for the status-flag instruction execution block
module testbench
   import sfx_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // Stimulus, observed outputs and bookkeeping
   // ----------------------------------------------------------------
   logic       i_clk     = 1'b0;
   logic       i_rst_n   = 1'b0;
   logic       i_valid   = 1'b0;
   logic [4:0] i_op      = 5'h00;
   logic [4:0] i_rd_addr = 5'h00;
   logic [2:0] i_bit_sel = 3'h0;
   logic [7:0] i_rd_data = 8'h00;
   logic [7:0] o_status;
   logic       o_rd_we;
   logic [4:0] o_rd_waddr;
   logic [7:0] o_rd_wdata;
   logic       o_sleep_req;
   logic       o_wdt_restart;
   logic       o_pc_advance;
   logic       o_illegal;
   logic [7:0] exp_status = 8'h00;
   int         num_errors      = 0;
   int         samples_checked = 0;
   // Pulse vector bits: write, sleep, watchdog, advance, illegal
   localparam logic [7:0] P_WE = 8'h10, P_SLP = 8'h08, P_WDT = 8'h04, P_PC = 8'h02, P_ILL = 8'h01;
   sfx_op_t set_ops [8] = '{SFX_OP_SET_CARRY, SFX_OP_SET_ZERO, SFX_OP_SET_NEGATIVE, SFX_OP_SET_OVERFLOW,
                            SFX_OP_SET_SIGN_FLAG, SFX_OP_SET_HALF_CARRY, SFX_OP_SET_TRANSFER, SFX_OP_SET_INT_ENABLE};
   sfx_op_t clr_ops [8] = '{SFX_OP_CLEAR_CARRY, SFX_OP_CLEAR_ZERO, SFX_OP_CLEAR_NEGATIVE, SFX_OP_CLEAR_OVERFLOW,
                            SFX_OP_CLEAR_SIGN_FLAG, SFX_OP_CLEAR_HALF_CARRY, SFX_OP_CLEAR_TRANSFER,
                            SFX_OP_CLEAR_INT_ENABLE};
   logic [7:0] flag_bit [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};

   // Clock, 5 ns period
   always #2.5 i_clk = ~i_clk;

   sfx_exec #(.REG_ADDR_W(5)) i_sfx_exec (
      .i_clk         (i_clk),
      .i_rst_n       (i_rst_n),
      .i_valid       (i_valid),
      .i_op          (i_op),
      .i_rd_addr     (i_rd_addr),
      .i_bit_sel     (i_bit_sel),
      .i_rd_data     (i_rd_data),
      .o_status      (o_status),
      .o_rd_we       (o_rd_we),
      .o_rd_waddr    (o_rd_waddr),
      .o_rd_wdata    (o_rd_wdata),
      .o_sleep_req   (o_sleep_req),
      .o_wdt_restart (o_wdt_restart),
      .o_pc_advance  (o_pc_advance),
      .o_illegal     (o_illegal)
   );

   // ----------------------------------------------------------------
   // Shared helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] pulses();
      return {3'h0, o_rd_we, o_sleep_req, o_wdt_restart, o_pc_advance, o_illegal};
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Present one instruction for one edge, return just after that edge
   task automatic issue(input logic [4:0] op, input logic [4:0] a, input logic [2:0] b, input logic [7:0] d,
                        input logic v = 1'b1);
      i_valid   = v;
      i_op      = op;
      i_rd_addr = a;
      i_bit_sel = b;
      i_rd_data = d;
      repeat (SFX_EXEC_CYCLES) @(posedge i_clk);
      #1;
   endtask

   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Each flag set back to back, then clear-set-clear on each flag
   task automatic t_flags();
      for (int i = 0; i < 8; i++) begin
         issue(set_ops[i], 5'h00, 3'h0, 8'h00);
         exp_status = exp_status | flag_bit[i];
         check(o_status, exp_status, "flag set");
         check(pulses(), P_PC, "flag set pulses");
      end
      for (int i = 7; i >= 0; i--) begin
         for (int k = 0; k < 3; k++) begin
            issue((k == 1) ? set_ops[i] : clr_ops[i], 5'h00, 3'h0, 8'h00);
            exp_status = (k == 1) ? (exp_status | flag_bit[i]) : (exp_status & ~flag_bit[i]);
            check(o_status, exp_status, "flag toggle");
         end
      end
   endtask

   // Bit load of a set transfer flag into every bit position, and of a clear one into bit 5
   task automatic t_bitload();
      issue(SFX_OP_SET_TRANSFER, 5'h00, 3'h0, 8'h00);
      exp_status = 8'h41;
      issue(SFX_OP_SET_CARRY, 5'h00, 3'h0, 8'h00);
      for (int b = 0; b < 8; b++) begin
         issue(SFX_OP_BIT_LOAD_FROM_TRANSFER, 5'(b + 24), 3'(b), 8'h00);
         check(o_rd_wdata, 8'h01 << b, "load one data");
         check({3'h0, o_rd_waddr}, 8'(b + 24), "load address");
         check(pulses(), P_WE | P_PC, "load pulses");
         check(o_status, exp_status, "load status");
      end
      issue(SFX_OP_CLEAR_TRANSFER, 5'h00, 3'h0, 8'h00);
      issue(SFX_OP_BIT_LOAD_FROM_TRANSFER, 5'h1F, 3'h5, 8'hFF);
      exp_status = 8'h01;
      check(o_rd_wdata, 8'hDF, "load zero data");
      check(o_status, exp_status, "load status");
      issue(SFX_OP_NO_OPERATION, 5'h02, 3'h1, 8'h55);
      check(pulses(), P_PC, "nop pulses");
      check(o_rd_wdata, 8'hDF, "write data held");
      check(o_status, exp_status, "nop status");
   endtask

   // No-op, sleep, watchdog restart, idle and unused codes
   task automatic t_misc();
      issue(SFX_OP_SET_SIGN_FLAG, 5'h00, 3'h0, 8'h00);
      exp_status = 8'h11;
      issue(SFX_OP_SLEEP, 5'h00, 3'h0, 8'h00);
      check(pulses(), P_SLP | P_PC, "sleep pulses");
      check(o_status, exp_status, "sleep status");
      issue(SFX_OP_WATCHDOG_RESTART, 5'h00, 3'h0, 8'h00);
      check(pulses(), P_WDT | P_PC, "watchdog pulses");
      check(o_status, exp_status, "watchdog status");
      issue(SFX_OP_NO_OPERATION, 5'h00, 3'h0, 8'h00);
      check(pulses(), P_PC, "nop pulses");
      check(o_status, exp_status, "nop status");
      issue(SFX_OP_CLEAR_CARRY, 5'h00, 3'h0, 8'h00, 1'b0);
      check(pulses(), 8'h00, "idle pulses");
      check(o_status, exp_status, "idle status");
      for (int c = 20; c < 32; c++) begin
         issue(5'(c), 5'h00, 3'h0, 8'h00);
         check(pulses(), P_ILL, "unused code pulses");
         check(o_status, exp_status, "unused code status");
      end
      issue(SFX_OP_NO_OPERATION, 5'h00, 3'h0, 8'h00, 1'b0);
      check(pulses(), 8'h00, "pulses drop");
   endtask

   // Reset in mid-run clears flags and pulses at once; work resumes on the first edge
   task automatic t_reset();
      issue(SFX_OP_SET_INT_ENABLE, 5'h00, 3'h0, 8'h00);
      issue(SFX_OP_SLEEP, 5'h00, 3'h0, 8'h00);
      i_rst_n = 1'b0;
      #1;
      check(o_status, SFX_STATUS_RST, "status after reset");
      check(pulses(), 8'h00, "pulses after reset");
      @(posedge i_clk);
      #1;
      i_rst_n    = 1'b1;
      exp_status = SFX_STATUS_RST | flag_bit[1];
      issue(SFX_OP_SET_ZERO, 5'h00, 3'h0, 8'h00);
      check(o_status, exp_status, "first op after reset");
      check(pulses(), P_PC, "first pulses after reset");
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (20) @(posedge i_clk);
      #1;
      check(o_status, SFX_STATUS_RST, "status in reset");
      check(pulses(), 8'h00, "pulses in reset");
      i_rst_n = 1'b1;
      t_flags();
      t_bitload();
      t_misc();
      t_reset();
      close_out();
   end

   initial begin
      #5000;
      num_errors++;
      $display("unexpected at %0t: run did not complete", $time);
      close_out();
   end

endmodule // testbench
